/* src/vmop_pkg.sv */
// Purpose: Shared constants for the video memory output port.
// Assumes: Core clock core_clk at 125 MHz.
// Notes:   Formats and timing counts used by the port and its helpers.
package vmop_pkg;
  localparam int          DATA_W        = 32;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          HALF_LEVEL    = 8;
  localparam int          PTR_W         = 4;
  localparam int          CNT_W         = 5;
  localparam int          POS_W         = 11;
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          HOLD_TICKS    = 2;
  localparam int          PULSE_TICKS   = 4;
  localparam logic [31:0] FILL_PIXEL    = 32'h0000_0000;
  localparam logic [1:0]  FMT_RGB555    = 2'h0;
  localparam logic [1:0]  FMT_YUV32     = 2'h1;
  localparam logic [1:0]  FMT_YUV16     = 2'h2;
  localparam logic [1:0]  FMT_MONO      = 2'h3;
  localparam int          KEY_BIT_POS   = 7;

  typedef enum logic [2:0] {
    inc_idle  = 3'b000,
    inc_pulse = 3'b001,
    inc_hold  = 3'b011,
    inc_gap   = 3'b010,
    inc_extra = 3'b110
  } inc_state_e;
endpackage : vmop_pkg

/* src/vmop_sync.sv */
// Purpose: Two flip-flop synchroniser for one level.
// Assumes: Input comes from outside the core_clk domain.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module vmop_sync #(
  parameter logic INIT = 1'b0 // level shown during reset
) (
  input  wire logic core_clk, // core clock
  input  wire logic rst_b,    // async reset, active low
  input  wire logic async_in, // unsynchronised level
  output logic      sync_out  // synchronised level
);
  logic meta;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta     <= INIT;
      sync_out <= INIT;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : vmop_sync
`default_nettype wire

/* src/vmop_fifo.sv */
// Purpose: Output word FIFO with level count.
// Assumes: Writes while full and reads while empty are refused.
// Notes:   Depth must be a power of two.
`timescale 1ns/1ps
`default_nettype none
module vmop_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             core_clk, // core clock
  input  wire logic             rst_b,    // async reset, active low
  input  wire logic             wr_valid, // write request
  output logic                  wr_ready, // not full
  input  wire logic [WIDTH-1:0] wr_data,  // word to store
  input  wire logic             rd_en,    // pop one word
  output logic                  rd_valid, // not empty
  output logic      [WIDTH-1:0] rd_data,  // oldest word
  output logic      [AW:0]      level     // words stored
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             do_wr;
  logic             do_rd;

  assign wr_ready = (level != (AW+1)'(DEPTH));
  assign rd_valid = (level != '0);
  assign do_wr    = wr_valid && wr_ready;
  assign do_rd    = rd_en && rd_valid;
  assign rd_data  = mem[rd_ptr];

  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      case ({do_wr, do_rd})
        2'b10:   level <= level + 1'b1;
        2'b01:   level <= level - 1'b1;
        default: level <= level;
      endcase
    end
  end
endmodule : vmop_fifo
`default_nettype wire

/* src/video_memory_output_port.sv */
// Purpose: Output port of a video scaler towards an external frame memory.
// Assumes: core_clk is the line-locked clock domain; one pix_tick per pixel.
// Notes:   Burst and transparent transfer modes, address increment strobe.
// Notes on behaviour
// - Select bit low runs the asynchronous burst mode for every format.
// - Half-full flag high while the FIFO holds eight or more words.
// - In burst mode leftover pixels at line end are padded up to half full.
// - Strobe rising with flag high means end of line.
// - Strobe rising with flag low means end of field or frame.
// - Strobe sequence depends on field format and field control bits.
// - Burst mode presents a new word at each memory clock rise.
// - In burst mode the data bus is driven only while output enable low is low.
// - Memory clock pulses with enable high still advance the FIFO.
// - Select bit high drives a continuous clock and streams data.
// - Transparent mode uses the extended output formats.
// - Transparent mode carries the key bit inside the lower byte.
// - Field output follows the internal odd/even field state.
// - Vertical sync active level follows its polarity bit.
// - Horizontal gate is high from window start to start plus size.
// - Pixel qualifier active level follows its polarity bit.
// - Interlaced output gives two sequences per line if field control bit 1 is set, one extra at odd if bit 0 is set.
// - Flag stays stable at least two line clocks after the strobe.
// - Sleep while the clock selection points at an inactive input.
// - Scaling resumes when the routing again selects an active clock.
`timescale 1ns/1ps
`default_nettype none
module video_memory_output_port
  import vmop_pkg::*;
#(
  parameter int FIFO_DEPTH_P = vmop_pkg::FIFO_DEPTH
) (
  input  wire logic                        core_clk,               // core clock
  input  wire logic                        rst_b,                  // reset
  input  wire logic                        pix_tick,               // pixel enable
  input  wire logic                        transfer_timing_select, // 1 = sync
  input  wire logic                        extended_format_select, // ext
  input  wire logic [1:0]                  format_select,          // format
  input  wire logic                        output_field_ctrl_1,    // field ctl
  input  wire logic                        output_field_ctrl_0,    // field ctl
  input  wire logic                        interlaced,             // interlace
  input  wire logic                        vsync_polarity_bit,     // vs pol
  input  wire logic                        qualifier_polarity_bit, // q pol
  input  wire logic [vmop_pkg::POS_W-1:0]  window_start_position,  // h start
  input  wire logic [vmop_pkg::POS_W-1:0]  window_size,            // h size
  input  wire logic                        clock_source_route,     // route
  input  wire logic                        clock_select_bit,       // select
  input  wire logic                        alt_clock_active,       // alt clk
  input  wire logic                        io_clock_active,        // io clk
  input  wire logic                        pix_valid,              // pixel in
  output logic                             pix_ready,              // can take
  input  wire logic [vmop_pkg::DATA_W-1:0] pix_data,               // pixel word
  input  wire logic                        key_bit,                // key bit
  input  wire logic                        line_end,               // line end
  input  wire logic                        field_end,              // field end
  input  wire logic                        odd_field,              // field
  input  wire logic                        vsync_int,              // vsync
  input  wire logic [vmop_pkg::POS_W-1:0]  h_position,             // h count
  input  wire logic                        memory_side_clock_i,    // clk pin in
  output logic                             memory_side_clock_o,    // clk out
  output logic                             memory_side_clock_oe,   // clk drive
  input  wire logic                        output_enable_n,        // bus oe_n
  output logic [vmop_pkg::DATA_W-1:0]      output_data_bus,        // data out
  output logic                             output_data_oe,         // bus drive
  output logic                             half_full_flag,         // request
  output logic                             address_increment_strobe, // inc
  output logic                             field_output,           // field
  output logic                             vertical_sync_output,   // vsync
  output logic                             horizontal_gate_output, // h gate
  output logic                             pixel_qualifier_output, // qualifier
  output logic                             scaler_sleep            // sleep
);
  import vmop_pkg::*;

  localparam int AW = $clog2(FIFO_DEPTH_P);

  logic              mclk_s;
  logic              oen_s;
  logic              mclk_d;
  logic              mclk_rise;
  logic              burst_mode;
  logic              fifo_wr;
  logic              fifo_wr_rdy;
  logic [DATA_W-1:0] fifo_wdata;
  logic              fifo_rd;
  logic              fifo_rvalid;
  logic [DATA_W-1:0] fifo_rdata;
  logic [AW:0]       level;
  logic              padding;
  logic              flag_raw;
  logic [1:0]        hold_cnt;
  logic [2:0]        pulse_cnt;
  logic [1:0]        seq_left;
  logic              seq_is_field;
  logic              extra_pending;
  logic              qual;
  logic [DATA_W-1:0] fmt_word;
  inc_state_e        inc_state;
  logic [POS_W:0]    win_end;

  function automatic logic [DATA_W-1:0] put_key(input logic [DATA_W-1:0] w,
                                                input logic k);
    logic [DATA_W-1:0] r;
    r = w;
    r[KEY_BIT_POS] = k;
    return r;
  endfunction : put_key

  vmop_sync u_sync_mclk (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in (memory_side_clock_i),
    .sync_out (mclk_s)
  );

  vmop_sync #(.INIT(1'b1)) u_sync_oen (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in (output_enable_n),
    .sync_out (oen_s)
  );

  assign burst_mode = !transfer_timing_select;

  // Sleep when the selected scaler clock input is inactive.
  // Selecting an active input again clears it and scaling resumes.
  assign scaler_sleep = clock_select_bit &&
                        (clock_source_route ? !io_clock_active
                                            : !alt_clock_active);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mclk_d <= 1'b0;
    end else begin
      mclk_d <= mclk_s;
    end
  end
  assign mclk_rise = mclk_s && !mclk_d;

  // Extended formats are forced in transparent mode.
  always_comb begin
    fmt_word = pix_data;
    if ((transfer_timing_select || extended_format_select) &&
        format_select == FMT_MONO) begin
      fmt_word[23:16] = pix_data[31:24];
    end
    if (transfer_timing_select) begin
      fmt_word = put_key(fmt_word, key_bit);
    end
  end

  // Padding inserts fill words; the scaler is stalled meanwhile.
  assign fifo_wr    = padding ? 1'b1 : (pix_valid && !scaler_sleep);
  assign fifo_wdata = padding ? FILL_PIXEL : fmt_word;
  assign pix_ready  = fifo_wr_rdy && !padding && !scaler_sleep;
  // Enable high does not block the read: pulses still advance.
  assign fifo_rd    = burst_mode ? mclk_rise : pix_tick;

  vmop_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH_P),
    .AW    (AW)
  ) u_fifo (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wr_valid (fifo_wr),
    .wr_ready (fifo_wr_rdy),
    .wr_data  (fifo_wdata),
    .rd_en    (fifo_rd),
    .rd_valid (fifo_rvalid),
    .rd_data  (fifo_rdata),
    .level    (level)
  );

  // In burst mode, pad a partly filled FIFO at line end up to the half level.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      padding <= 1'b0;
    end else if (padding) begin
      if (level >= (AW+1)'(HALF_LEVEL - 1)) begin
        padding <= 1'b0;
      end
    end else if (burst_mode && line_end && level != '0 &&
                 level < (AW+1)'(HALF_LEVEL)) begin
      padding <= 1'b1;
    end
  end

  assign flag_raw = (level >= (AW+1)'(HALF_LEVEL));

  // The flag is frozen for two line clocks after each strobe rise so
  // the controller samples a stable end-of-line or end-of-field code.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      half_full_flag <= 1'b0;
      hold_cnt       <= 2'h0;
    end else if (hold_cnt != 2'h0) begin
      if (pix_tick) begin
        hold_cnt <= hold_cnt - 2'h1;
      end
    end else if (inc_state == inc_pulse && pulse_cnt == 3'h0) begin
      half_full_flag <= !seq_is_field;
      hold_cnt       <= 2'(HOLD_TICKS);
    end else begin
      half_full_flag <= flag_raw;
    end
  end

  // Strobe sequencer: line ends met with flag_raw low and no padding under way give one sequence, or two if interlaced with output_field_ctrl_1 set;
  // field ends give one, plus one extra at the start of an odd field if interlaced with output_field_ctrl_0 set.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      inc_state     <= inc_idle;
      pulse_cnt     <= 3'h0;
      seq_left      <= 2'h0;
      seq_is_field  <= 1'b0;
      extra_pending <= 1'b0;
      address_increment_strobe <= 1'b0;
    end else begin
      case (inc_state)
        inc_idle: begin
          address_increment_strobe <= 1'b0;
          if (field_end) begin
            seq_is_field  <= 1'b1;
            seq_left      <= 2'h1;
            extra_pending <= interlaced && output_field_ctrl_0 &&
                             !odd_field;
            inc_state     <= inc_pulse;
            pulse_cnt     <= 3'h0;
          end else if (line_end && !flag_raw && !padding) begin
            seq_is_field <= 1'b0;
            seq_left     <= (interlaced && output_field_ctrl_1) ?
                            2'h2 : 2'h1;
            inc_state    <= inc_pulse;
            pulse_cnt    <= 3'h0;
          end
        end
        inc_pulse: begin
          address_increment_strobe <= 1'b1;
          if (pix_tick) begin
            pulse_cnt <= pulse_cnt + 3'h1;
          end
          if (pulse_cnt == 3'(PULSE_TICKS)) begin
            inc_state <= inc_hold;
            seq_left  <= seq_left - 2'h1;
          end
        end
        inc_hold: begin
          address_increment_strobe <= 1'b0;
          if (hold_cnt == 2'h0) begin
            inc_state <= inc_gap;
          end
        end
        inc_gap: begin
          pulse_cnt <= 3'h0;
          if (seq_left != 2'h0) begin
            inc_state <= inc_pulse;
          end else if (extra_pending) begin
            inc_state <= inc_extra;
          end else begin
            inc_state <= inc_idle;
          end
        end
        inc_extra: begin
          extra_pending <= 1'b0;
          seq_is_field  <= 1'b0;
          seq_left      <= 2'h1;
          inc_state     <= inc_pulse;
        end
        default: begin
          inc_state <= inc_idle;
          address_increment_strobe <= 1'b0;
        end
      endcase
    end
  end

  // Data register; in burst mode the pin driver is released while enable is high.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      output_data_bus <= '0;
    end else if (fifo_rd && fifo_rvalid) begin
      output_data_bus <= fifo_rdata;
    end
  end
  assign output_data_oe = burst_mode ? !oen_s : 1'b1;

  // Transparent mode drives a line rate clock; burst mode takes it in.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      memory_side_clock_o <= 1'b0;
    end else if (pix_tick) begin
      memory_side_clock_o <= 1'b1;
    end else begin
      memory_side_clock_o <= 1'b0;
    end
  end
  assign memory_side_clock_oe = transfer_timing_select;

  assign win_end = {1'b0, window_start_position} + {1'b0, window_size};
  assign qual    = fifo_rvalid && !scaler_sleep;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      field_output           <= 1'b0;
      vertical_sync_output   <= 1'b0;
      horizontal_gate_output <= 1'b0;
      pixel_qualifier_output <= 1'b0;
    end else begin
      field_output           <= odd_field;
      vertical_sync_output   <= vsync_int ^ !vsync_polarity_bit;
      horizontal_gate_output <= ({1'b0, h_position} >=
                                 {1'b0, window_start_position}) &&
                                ({1'b0, h_position} < win_end);
      pixel_qualifier_output <= qual ^ !qualifier_polarity_bit;
    end
  end
endmodule : video_memory_output_port
`default_nettype wire

/* tb/vmop_checker.sv */
// Purpose: Port assertions for the video memory output port.
// Assumes: One core_clk domain, rst_b async low.
// Notes:   Bound to every instance of the port.
`timescale 1ns/1ps
`default_nettype none
module vmop_checker
  import vmop_pkg::*;
(
  input wire logic              core_clk,                 // clock
  input wire logic              rst_b,                    // reset
  input wire logic              transfer_timing_select,   // mode
  input wire logic              extended_format_select,   // ext
  input wire logic [1:0]        format_select,            // format
  input wire logic              output_enable_n,          // bus oe_n
  input wire logic              output_data_oe,           // bus drive
  input wire logic              memory_side_clock_oe,     // clk drive
  input wire logic [DATA_W-1:0] output_data_bus,          // data
  input wire logic              vsync_int,                // vsync
  input wire logic              vsync_polarity_bit,       // vs pol
  input wire logic              vertical_sync_output,     // vs out
  input wire logic              odd_field,                // field
  input wire logic              field_output,             // field out
  input wire logic [POS_W-1:0]  h_position,               // h count
  input wire logic [POS_W-1:0]  window_start_position,    // h start
  input wire logic [POS_W-1:0]  window_size,              // h size
  input wire logic              horizontal_gate_output,   // gate
  input wire logic              address_increment_strobe, // inc
  input wire logic              half_full_flag,           // flag
  input wire logic              clock_select_bit,         // select
  input wire logic              clock_source_route,       // route
  input wire logic              alt_clock_active,         // alt
  input wire logic              io_clock_active,          // io
  input wire logic              scaler_sleep              // sleep
);
  logic mono;
  logic vs_want;
  logic in_win;
  logic gate_known;

  // The window end is left out: only the start edge and interior are fixed.
  assign mono = transfer_timing_select && extended_format_select &&
                format_select == FMT_MONO;
  assign vs_want = vsync_int == vsync_polarity_bit;
  assign in_win = h_position >= window_start_position &&
                  {1'b0, h_position} <
                  {1'b0, window_start_position} + {1'b0, window_size};
  assign gate_known = in_win || h_position < window_start_position;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  a_bus_released: assert property (
    (!transfer_timing_select && output_enable_n) [*3] |-> !output_data_oe)
    else $error("data bus driven while enable high");
  a_sync_drives: assert property (
    transfer_timing_select |-> output_data_oe && memory_side_clock_oe)
    else $error("transparent mode not driving");
  a_burst_no_clock: assert property (
    !transfer_timing_select |-> !memory_side_clock_oe)
    else $error("clock pin driven in burst mode");
  a_vsync_level: assert property (
    $past(rst_b) |-> vertical_sync_output == $past(vs_want))
    else $error("vertical sync level wrong");
  a_field_state: assert property (
    $past(rst_b) |-> field_output == $past(odd_field))
    else $error("field output wrong");
  a_gate_window: assert property (
    $past(rst_b) && $past(gate_known) |->
      horizontal_gate_output == $past(in_win))
    else $error("horizontal gate wrong");
  a_strobe_width: assert property (
    $rose(address_increment_strobe) |-> address_increment_strobe [*4])
    else $error("increment pulse too short");
  a_flag_frozen: assert property (
    $rose(address_increment_strobe) |=> $stable(half_full_flag) [*2])
    else $error("flag moved after increment pulse");
  a_sleep_select: assert property (
    scaler_sleep == (clock_select_bit &&
      !(clock_source_route ? io_clock_active : alt_clock_active)))
    else $error("sleep state wrong");
  a_mono_copy: assert property (
    mono && $past(mono) && $changed(output_data_bus) |->
      output_data_bus[23:16] == output_data_bus[31:24])
    else $error("monochrome slots differ");
endmodule : vmop_checker

bind video_memory_output_port vmop_checker u_chk (.*);
`default_nettype wire

/* tb/vmop_mem_ctrl.sv */
// Purpose: Behavioural frame memory controller on the burst port.
// Assumes: Its strobe clock has a 125 ns period, unrelated to core_clk.
// Notes:   Undriven reads are logged as all ones.
`timescale 1ns/1ps
`default_nettype none
module vmop_mem_ctrl (
  input  wire logic        run,                      // allow bursts
  input  wire logic        oe_block,                 // keep bus off
  input  wire logic        half_full_flag,           // request
  input  wire logic        address_increment_strobe, // address step
  input  wire logic [31:0] output_data_bus,          // data
  input  wire logic        output_data_oe,           // bus driven
  output logic             mclk,                     // memory clock
  output logic             oen                       // enable, low
);
  logic [31:0] got[$];
  int          lines;
  int          fields;

  // The clock stands low between bursts.
  initial begin
    mclk = 1'b0;
    oen = 1'b1;
    lines = 0;
    fields = 0;
    forever begin
      wait (run && half_full_flag);
      #40;
      oen = oe_block;
      repeat (8) begin
        #62.5 mclk = 1'b1;
        #62.5 mclk = 1'b0;
        got.push_back(output_data_oe ? output_data_bus : 32'hffff_ffff);
      end
      oen = 1'b1;
      #200;
    end
  end

  always @(posedge address_increment_strobe) begin
    #1;
    if (half_full_flag) lines++;
    else fields++;
  end
endmodule : vmop_mem_ctrl
`default_nettype wire

/* tb/video_memory_output_port_test.sv */
// Purpose: Self-checking bench for the video memory output port.
// Assumes: pix_tick held high but for two cycles in t_trans, one line clock per core_clk cycle.
// Notes:   Burst reads go through the controller model.
`timescale 1ns/1ps
`default_nettype none
module video_memory_output_port_test;
  import vmop_pkg::*;
  logic core_clk, rst_b, pix_tick, transfer_timing_select, run, oe_block;
  logic extended_format_select, output_field_ctrl_1, output_field_ctrl_0;
  logic interlaced, vsync_polarity_bit, qualifier_polarity_bit, mclk, oen;
  logic [1:0] format_select;
  logic [POS_W-1:0] window_start_position, window_size, h_position;
  logic clock_source_route, clock_select_bit, alt_clock_active;
  logic io_clock_active, pix_valid, pix_ready, key_bit, line_end;
  logic field_end, odd_field, vsync_int, output_data_oe, field_output;
  logic [DATA_W-1:0] pix_data, output_data_bus;
  logic memory_side_clock_o, memory_side_clock_oe, half_full_flag;
  logic address_increment_strobe, vertical_sync_output, scaler_sleep;
  logic horizontal_gate_output, pixel_qualifier_output;
  int error_cnt, check_count;

  video_memory_output_port #(.FIFO_DEPTH_P(FIFO_DEPTH)) dut (
    .memory_side_clock_i(mclk), .output_enable_n(oen), .*);
  vmop_mem_ctrl mc (.*);

  always #4 core_clk = ~core_clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask : step

  task automatic put_n(input logic [31:0] base, input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      pix_data <= base + i;
      pix_valid <= 1'b1;
      k = 0;
      do begin
        @(posedge core_clk);
        k++;
      end while (pix_ready !== 1'b1 && k < 50);
      if (pix_ready !== 1'b1) begin
        error_cnt++;
        stop_test();
      end
    end
    pix_valid <= 1'b0;
  endtask : put_n

  task automatic wait_got(input int n);
    int k;
    for (k = 0; k < 4000 && mc.got.size() < n; k++) step(1);
    if (k == 4000) begin
      error_cnt++;
      stop_test();
    end
  endtask : wait_got

  task automatic t_burst();
    int b;
    b = mc.got.size();
    put_n(32'h1000_0000, 12);
    step(2);
    chk("half full", 1, half_full_flag);
    wait_got(b + 8);
    for (int i = 0; i < 8; i++)
      chk("burst word", 32'h1000_0000 + i, mc.got[b + i]);
    step(4);
    chk("flag low", 0, half_full_flag);
    b = mc.got.size();
    line_end <= 1'b1;
    step(1);
    line_end <= 1'b0;
    step(3);
    chk("padded flag", 1, half_full_flag);
    wait_got(b + 8);
    for (int i = 0; i < 8; i++)
      chk("padded word", i < 4 ? 32'h1000_0008 + i : FILL_PIXEL,
          mc.got[b + i]);
    $display("test burst done");
  endtask : t_burst

  task automatic inc_case(input logic il, c1, c0, fe, input int el, ef);
    int l;
    int f;
    l = mc.lines;
    f = mc.fields;
    interlaced <= il;
    output_field_ctrl_1 <= c1;
    output_field_ctrl_0 <= c0;
    step(1);
    if (fe) field_end <= 1'b1;
    else line_end <= 1'b1;
    step(1);
    field_end <= 1'b0;
    line_end <= 1'b0;
    step(60);
    chk("line steps", el, mc.lines - l);
    chk("field steps", ef, mc.fields - f);
    $display("test increment done");
  endtask : inc_case

  task automatic t_oe();
    int b;
    oe_block <= 1'b1;
    b = mc.got.size();
    put_n(32'h2000_0000, 8);
    wait_got(b + 8);
    for (int i = 0; i < 8; i++)
      chk("undriven read", 32'hffff_ffff, mc.got[b + i]);
    step(4);
    chk("drained flag", 0, half_full_flag);
    oe_block <= 1'b0;
    $display("test enable done");
  endtask : t_oe

  task automatic t_refs();
    for (int p = 0; p < 2; p++) begin
      vsync_polarity_bit <= p[0];
      qualifier_polarity_bit <= p[0];
      odd_field <= p[0];
      h_position <= 11'h00c;
      step(3);
      chk("vsync", p, vertical_sync_output);
      chk("field", p, field_output);
      chk("qualifier idle", p == 0, pixel_qualifier_output);
      chk("gate in", 1, horizontal_gate_output);
      h_position <= 11'h005;
      step(3);
      chk("gate out", 0, horizontal_gate_output);
    end
    $display("test references done");
  endtask : t_refs

  task automatic t_sleep();
    for (int r = 0; r < 2; r++) begin
      clock_select_bit <= 1'b1;
      clock_source_route <= r[0];
      alt_clock_active <= r[0];
      io_clock_active <= !r[0];
      step(2);
      chk("sleep", 1, scaler_sleep);
      chk("ready in sleep", 0, pix_ready);
      alt_clock_active <= 1'b1;
      io_clock_active <= 1'b1;
      step(2);
      chk("awake", 0, scaler_sleep);
    end
    clock_select_bit <= 1'b0;
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_trans();
    transfer_timing_select <= 1'b1;
    extended_format_select <= 1'b1;
    format_select <= FMT_MONO;
    step(2);
    chk("clock pin driven", 1, memory_side_clock_oe);
    put_n(32'hab00_0000, 1);
    step(6);
    chk("mono slots", 32'habab, output_data_bus[31:16]);
    chk("key bit", 1, output_data_bus[KEY_BIT_POS]);
    pix_tick <= 1'b0;
    step(2);
    chk("clock out", 0, memory_side_clock_o);
    pix_tick <= 1'b1;
    $display("test transparent done");
  endtask : t_trans

  initial begin
    {core_clk, rst_b, transfer_timing_select, extended_format_select} = '0;
    {output_field_ctrl_1, output_field_ctrl_0, interlaced, oe_block} = '0;
    {qualifier_polarity_bit, vsync_polarity_bit, clock_source_route} = '0;
    {clock_select_bit, pix_valid, line_end, field_end, odd_field} = '0;
    {pix_tick, alt_clock_active, io_clock_active, vsync_int, key_bit} = '1;
    run = 1'b1;
    format_select = FMT_YUV32;
    window_start_position = 11'h00a;
    window_size = 11'h014;
    h_position = '0;
    pix_data = '0;
    error_cnt = 0;
    check_count = 0;
    step(2);
    rst_b <= 1'b1;
    step(2);
    chk("reset flag", 0, half_full_flag);
    t_burst();
    run <= 1'b0;
    inc_case(0, 0, 0, 0, 1, 0);
    inc_case(1, 1, 0, 0, 2, 0);
    inc_case(0, 0, 0, 1, 0, 1);
    inc_case(1, 0, 1, 1, 1, 1);
    run <= 1'b1;
    t_oe();
    t_refs();
    t_sleep();
    t_trans();
    stop_test();
  end
endmodule : video_memory_output_port_test
`default_nettype wire
